// ==== l2_action_filter_pkg.sv ====
package l2_action_filter_pkg;
    localparam int NUM_PORTS = 11;
    localparam int ENTRY_W = 19;
    localparam int TBL_DEPTH = 128;
    localparam int ADDR_W = 20;
    localparam logic [17:0] DEST_TBL_IDX = 18'h1BDDA;
    localparam logic [17:0] SRC_TBL_IDX = 18'h1BE5A;
    localparam logic [17:0] EGR_STATE_IDX = 18'h1E784;
    localparam logic [17:0] DROP_CNT_IDX = 18'h1E785;
    localparam logic [ENTRY_W-1:0] ENTRY_RST = 19'h00000;
    localparam logic [NUM_PORTS-1:0] EGR_STATE_RST = 11'h000;
    localparam int B_SUPPRESS_LEARN_UNICAST = 0;
    localparam int B_SUPPRESS_LEARN_MULTICAST = 1;
    localparam int B_DISCARD_EVERY_COPY = 2;
    localparam int B_DISCARD_PORT = 3;
    localparam int B_DISCARD_ON_STATION_MOVE = 4;
    localparam int B_COPY_TO_HOST = 5;
    localparam int B_HOST_COPY_UNMODIFIED = 6;
    localparam int B_FORBID_STATION_MOVE = 7;
    localparam int B_SPECIAL_FRAME_CHECK_EN = 8;
    localparam int B_RULE_SEL_LO = 9;
    localparam int B_PROFILE_VALID = 11;
    localparam int B_PROFILE_INDEX_LO = 12;
    localparam int B_PROFILE_PRIO_LO = 17;
    localparam int B_DEST_UNICAST_FLAG = 0;
    localparam int B_DEST_ENTRY_STATUS = 8;
    localparam int B_SRC_ENTRY_STATUS = 9;
    localparam logic [1:0] PT_UNICAST = 2'h0;
    localparam logic [1:0] PT_MULTICAST = 2'h1;
    localparam logic [1:0] PT_FLOOD = 2'h2;
    localparam logic [1:0] PT_BROADCAST = 2'h3;
endpackage

// ==== l2_action_filter_lookup.sv ====
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module l2_action_filter_lookup (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic [19:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_PKT_VALID,
    input wire logic I_SOURCE_PORT_STATE_BIT,
    input wire logic I_SOURCE_ACTION_LOOKUP_EN,
    input wire logic I_SRC_HIT,
    input wire logic [9:0] I_SRC_ENTRY,
    input wire logic I_DEST_HIT,
    input wire logic [9:0] I_DEST_ENTRY,
    input wire logic I_BROADCAST,
    input wire logic I_STATION_MOVE,
    input wire logic I_SRC_MAC_MC,
    input wire logic [10:0] I_DEST_PORTS,
    input wire logic [3:0] I_SPECIAL_ALLOWED,
    output logic O_RES_VALID,
    output logic [10:0] O_FWD_PORTS,
    output logic O_DROP,
    output logic O_SUPPRESS_LEARN,
    output logic O_COPY_TO_HOST,
    output logic O_HOST_COPY_UNMODIFIED,
    output logic O_FORBID_STATION_MOVE,
    output logic O_PROFILE_VALID,
    output logic [4:0] O_PROFILE_INDEX,
    output logic [1:0] O_PROFILE_PRIORITY
);
    localparam int NP = l2_action_filter_pkg::NUM_PORTS;
    localparam int EW = l2_action_filter_pkg::ENTRY_W;

    logic [EW-1:0] dest_table [l2_action_filter_pkg::TBL_DEPTH];
    logic [EW-1:0] src_table [l2_action_filter_pkg::TBL_DEPTH];
    logic [NP-1:0] egress_state;
    logic [31:0] drop_count;
    logic bus_ack;
    logic [17:0] widx;
    logic bus_req;
    logic bus_take;
    logic [7:0] dest_hit_off;
    logic [7:0] src_hit_off;

    // Returns {in range, offset} for a table starting at base.
    function automatic logic [7:0] tbl_decode(input logic [17:0] idx, input logic [17:0] base);
        logic [17:0] d;
        d = idx - base;
        tbl_decode = {(d < 18'h00080), d[6:0]};
    endfunction

    // An entry's discard-every-copy is waived when its special frame rule admits the frame.
    // Special frame waiver.
    function automatic logic entry_drop_all(input logic [EW-1:0] e, input logic [3:0] allowed);
        logic admit;
        admit = e[l2_action_filter_pkg::B_SPECIAL_FRAME_CHECK_EN]
            & allowed[e[l2_action_filter_pkg::B_RULE_SEL_LO +: 2]];
        entry_drop_all = e[l2_action_filter_pkg::B_DISCARD_EVERY_COPY] & ~admit;
    endfunction

    assign widx = I_AVS_ADDRESS[19:2];
    assign bus_req = I_AVS_READ | I_AVS_WRITE;
    assign bus_take = bus_req & bus_ack;
    assign dest_hit_off = tbl_decode(widx, l2_action_filter_pkg::DEST_TBL_IDX);
    assign src_hit_off = tbl_decode(widx, l2_action_filter_pkg::SRC_TBL_IDX);

    // One wait cycle gives the registered read data time to settle.
    assign O_AVS_WAITREQUEST = bus_req & ~bus_ack;

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_AVS_READDATA <= 32'h00000000;
        end else if (I_AVS_READ & ~bus_ack) begin
            if (dest_hit_off[7]) begin
                O_AVS_READDATA <= {13'h0000, dest_table[dest_hit_off[6:0]]};
            end else if (src_hit_off[7]) begin
                O_AVS_READDATA <= {13'h0000, src_table[src_hit_off[6:0]]};
            end else if (widx == l2_action_filter_pkg::EGR_STATE_IDX) begin
                O_AVS_READDATA <= {21'h000000, egress_state};
            end else if (widx == l2_action_filter_pkg::DROP_CNT_IDX) begin
                O_AVS_READDATA <= drop_count;
            end else begin
                O_AVS_READDATA <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < l2_action_filter_pkg::TBL_DEPTH; i++) begin
                dest_table[i] <= l2_action_filter_pkg::ENTRY_RST;
                src_table[i] <= l2_action_filter_pkg::ENTRY_RST;
            end
        end else if (bus_take & I_AVS_WRITE) begin
            if (dest_hit_off[7]) begin
                dest_table[dest_hit_off[6:0]] <= I_AVS_WRITEDATA[EW-1:0];
            end
            if (src_hit_off[7]) begin
                src_table[src_hit_off[6:0]] <= I_AVS_WRITEDATA[EW-1:0];
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            egress_state <= l2_action_filter_pkg::EGR_STATE_RST;
        end else if (bus_take & I_AVS_WRITE & (widx == l2_action_filter_pkg::EGR_STATE_IDX)) begin
            egress_state <= I_AVS_WRITEDATA[NP-1:0];
        end
    end

    // Index composition shared by both tables.
    logic da_status;
    logic sa_status;
    logic [1:0] pkt_type;
    logic [5:0] low_idx;
    assign da_status = I_DEST_HIT & I_DEST_ENTRY[l2_action_filter_pkg::B_DEST_ENTRY_STATUS];
    assign sa_status = I_SRC_HIT & I_SRC_ENTRY[l2_action_filter_pkg::B_SRC_ENTRY_STATUS];

    always_comb begin
        if (!I_DEST_HIT && I_BROADCAST) begin
            pkt_type = l2_action_filter_pkg::PT_BROADCAST;
        end else if (!I_DEST_HIT) begin
            pkt_type = l2_action_filter_pkg::PT_FLOOD;
        end else if (I_DEST_ENTRY[l2_action_filter_pkg::B_DEST_UNICAST_FLAG]) begin
            pkt_type = l2_action_filter_pkg::PT_UNICAST;
        end else begin
            pkt_type = l2_action_filter_pkg::PT_MULTICAST;
        end
    end

    assign low_idx = {pkt_type, da_status, sa_status, I_SRC_HIT, I_SOURCE_PORT_STATE_BIT};

    logic [EW-1:0] port_act [NP];
    logic [EW-1:0] src_act;

    // Top bit from that port's state.
    for (genvar p = 0; p < NP; p++) begin : g_port
        assign port_act[p] = dest_table[{egress_state[p], low_idx}];
    end

    // Looked up regardless of destination ports.
    assign src_act = src_table[{I_STATION_MOVE, low_idx}];

    logic [EW-1:0] or_act;
    logic drop_all;
    logic [NP-1:0] port_drop;
    logic best_valid;
    logic [4:0] best_index;
    logic [1:0] best_prio;

    // Destination, source and ACL special-frame results meet here.
    always_comb begin
        or_act = '0;
        drop_all = 1'b0;
        port_drop = '0;
        best_valid = 1'b0;
        best_index = 5'h00;
        best_prio = 2'h0;
        for (int p = 0; p < NP; p++) begin
            if (I_DEST_PORTS[p]) begin
                or_act = or_act | port_act[p];
                drop_all = drop_all | entry_drop_all(port_act[p], I_SPECIAL_ALLOWED);
                port_drop[p] = port_act[p][l2_action_filter_pkg::B_DISCARD_PORT];
                if (port_act[p][l2_action_filter_pkg::B_PROFILE_VALID] && (!best_valid
                    || port_act[p][l2_action_filter_pkg::B_PROFILE_PRIO_LO +: 2] > best_prio)) begin
                    best_valid = 1'b1;
                    best_index = port_act[p][l2_action_filter_pkg::B_PROFILE_INDEX_LO +: 5];
                    best_prio = port_act[p][l2_action_filter_pkg::B_PROFILE_PRIO_LO +: 2];
                end
            end
        end
        if (I_SOURCE_ACTION_LOOKUP_EN) begin
            or_act = or_act | src_act;
            drop_all = drop_all | entry_drop_all(src_act, I_SPECIAL_ALLOWED);
            // A source-side per-port drop has no single port, so it covers all of them.
            if (src_act[l2_action_filter_pkg::B_DISCARD_PORT]) begin
                port_drop = '1;
            end
            if (src_act[l2_action_filter_pkg::B_PROFILE_VALID] && (!best_valid
                || src_act[l2_action_filter_pkg::B_PROFILE_PRIO_LO +: 2] > best_prio)) begin
                best_valid = 1'b1;
                best_index = src_act[l2_action_filter_pkg::B_PROFILE_INDEX_LO +: 5];
                best_prio = src_act[l2_action_filter_pkg::B_PROFILE_PRIO_LO +: 2];
            end
        end
    end

    logic move_drop;
    logic whole_drop;
    logic drop_event;
    logic next_learn_off;
    assign move_drop = or_act[l2_action_filter_pkg::B_DISCARD_ON_STATION_MOVE] & I_STATION_MOVE;
    assign whole_drop = drop_all | move_drop;
    assign drop_event = whole_drop | (|(I_DEST_PORTS & port_drop));
    assign next_learn_off =
        (or_act[l2_action_filter_pkg::B_SUPPRESS_LEARN_UNICAST]
            & (pkt_type == l2_action_filter_pkg::PT_UNICAST))
        | (or_act[l2_action_filter_pkg::B_SUPPRESS_LEARN_MULTICAST] & I_SRC_MAC_MC);

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RES_VALID <= 1'b0;
            O_FWD_PORTS <= '0;
            O_DROP <= 1'b0;
            O_SUPPRESS_LEARN <= 1'b0;
            O_COPY_TO_HOST <= 1'b0;
            O_HOST_COPY_UNMODIFIED <= 1'b0;
            O_FORBID_STATION_MOVE <= 1'b0;
            O_PROFILE_VALID <= 1'b0;
            O_PROFILE_INDEX <= 5'h00;
            O_PROFILE_PRIORITY <= 2'h0;
        end else begin
            O_RES_VALID <= I_PKT_VALID;
            if (I_PKT_VALID) begin
                O_FWD_PORTS <= whole_drop ? '0 : (I_DEST_PORTS & ~port_drop);
                O_DROP <= whole_drop;
                O_SUPPRESS_LEARN <= next_learn_off;
                O_COPY_TO_HOST <= or_act[l2_action_filter_pkg::B_COPY_TO_HOST];
                O_HOST_COPY_UNMODIFIED <= or_act[l2_action_filter_pkg::B_COPY_TO_HOST]
                    & or_act[l2_action_filter_pkg::B_HOST_COPY_UNMODIFIED];
                O_FORBID_STATION_MOVE <= or_act[l2_action_filter_pkg::B_FORBID_STATION_MOVE];
                O_PROFILE_VALID <= best_valid;
                O_PROFILE_INDEX <= best_index;
                O_PROFILE_PRIORITY <= best_prio;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            drop_count <= 32'h00000000;
        end else if (I_PKT_VALID & drop_event) begin
            drop_count <= drop_count + 32'h00000001;
        end
    end

    sequence s_bus_first;
        bus_req && !bus_ack;
    endsequence

    sequence s_bus_done;
        bus_req && !O_AVS_WAITREQUEST;
    endsequence

    a_bus_one_wait: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        s_bus_first ##1 bus_req |-> !O_AVS_WAITREQUEST)
        else $error("Bus request not answered after one wait cycle.");

    a_state_write: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        s_bus_done and (I_AVS_WRITE && widx == l2_action_filter_pkg::EGR_STATE_IDX)
        |=> egress_state == $past(I_AVS_WRITEDATA[NP-1:0]))
        else $error("Egress state write not stored.");

    a_drop_counts: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && drop_event |=> drop_count == $past(drop_count) + 32'h00000001)
        else $error("Action drop not counted.");

    a_whole_drop: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_SOURCE_ACTION_LOOKUP_EN
        && entry_drop_all(src_act, I_SPECIAL_ALLOWED) |=> O_DROP && O_FWD_PORTS == '0)
        else $error("Source discard-every-copy ignored.");

    a_port_subset: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID |=> (O_FWD_PORTS & ~$past(I_DEST_PORTS & ~port_drop)) == '0)
        else $error("Forwarded to a dropped or absent port.");

    a_move_drop: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_STATION_MOVE
        && or_act[l2_action_filter_pkg::B_DISCARD_ON_STATION_MOVE] |=> O_DROP)
        else $error("Station move discard missed.");

    a_unmod_copy: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        O_HOST_COPY_UNMODIFIED |-> O_COPY_TO_HOST)
        else $error("Unmodified copy without host copy.");

    a_result_valid: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID ##1 !I_PKT_VALID |-> O_RES_VALID ##1 !O_RES_VALID)
        else $error("Result valid not one cycle after packet.");

    a_src_gated: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && !I_SOURCE_ACTION_LOOKUP_EN && (I_DEST_PORTS == '0)
        |=> !O_DROP && !O_COPY_TO_HOST && !O_SUPPRESS_LEARN && !O_PROFILE_VALID)
        else $error("Disabled source entry reached the result.");

    a_special_waive: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_SOURCE_ACTION_LOOKUP_EN && (I_DEST_PORTS == '0)
        && src_act[l2_action_filter_pkg::B_SPECIAL_FRAME_CHECK_EN]
        && I_SPECIAL_ALLOWED[src_act[l2_action_filter_pkg::B_RULE_SEL_LO +: 2]]
        && !(src_act[l2_action_filter_pkg::B_DISCARD_ON_STATION_MOVE] && I_STATION_MOVE)
        |=> !O_DROP)
        else $error("Admitted special frame was discarded.");

    a_move_no_fwd: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && move_drop |=> O_DROP && (O_FWD_PORTS == '0))
        else $error("Station move discard still forwarded.");

    a_host_copy: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_DEST_PORTS[0] && port_act[0][l2_action_filter_pkg::B_COPY_TO_HOST]
        |=> O_COPY_TO_HOST)
        else $error("Host copy of port 0 entry missed.");

    a_forbid_move: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_DEST_PORTS[3]
        && port_act[3][l2_action_filter_pkg::B_FORBID_STATION_MOVE] |=> O_FORBID_STATION_MOVE)
        else $error("Station move not forbidden.");

    a_learn_uc: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_DEST_HIT && I_DEST_ENTRY[l2_action_filter_pkg::B_DEST_UNICAST_FLAG]
        && or_act[l2_action_filter_pkg::B_SUPPRESS_LEARN_UNICAST]
        |=> O_SUPPRESS_LEARN)
        else $error("Unicast learning not suppressed.");

    a_learn_mc: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_SRC_MAC_MC
        && or_act[l2_action_filter_pkg::B_SUPPRESS_LEARN_MULTICAST] |=> O_SUPPRESS_LEARN)
        else $error("Multicast learning not suppressed.");

    a_profile_gate: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        !O_PROFILE_VALID |-> (O_PROFILE_INDEX == 5'h00) && (O_PROFILE_PRIORITY == 2'h0))
        else $error("Profile pointer shown without its valid flag.");

    a_type_bcast: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        !I_DEST_HIT && I_BROADCAST |-> pkt_type == l2_action_filter_pkg::PT_BROADCAST)
        else $error("Broadcast miss not typed as broadcast.");

    a_miss_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (low_idx[3:2] & ~{I_DEST_HIT, I_SRC_HIT}) == 2'h0)
        else $error("Status index bit set on a lookup miss.");

    a_count_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        !(I_PKT_VALID && drop_event) |=> $stable(drop_count))
        else $error("Drop counter moved without a drop.");

    a_egress_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        !(bus_take && I_AVS_WRITE && (widx == l2_action_filter_pkg::EGR_STATE_IDX))
        |=> $stable(egress_state))
        else $error("Egress state changed without a write.");

    a_port_kept: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        I_PKT_VALID && I_DEST_PORTS[3] && !I_SOURCE_ACTION_LOOKUP_EN && !whole_drop
        && !port_act[3][l2_action_filter_pkg::B_DISCARD_PORT] |=> O_FWD_PORTS[3])
        else $error("Port 3 removed without a per-port discard.");
endmodule
`default_nettype wire

// ==== l2_lookup_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module l2_lookup_stage_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_send,
    input wire logic [41:0] i_pkt,
    output logic o_pkt_valid,
    output logic [41:0] o_fields
);
    // Between packets the fields flip every cycle, so a late sample shows up as garbage.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pkt_valid <= 1'b0;
            o_fields <= 42'h0;
        end else if (i_send) begin
            o_pkt_valid <= 1'b1;
            o_fields <= i_pkt;
        end else begin
            o_pkt_valid <= 1'b0;
            o_fields <= ~o_fields;
        end
    end
endmodule
`default_nettype wire

// ==== tb_l2_action_filter_lookup.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_l2_action_filter_lookup;
    typedef struct packed {
        logic st; logic en; logic sh; logic [9:0] se; logic dh; logic [9:0] de;
        logic bc; logic mv; logic mc; logic [10:0] ports; logic [3:0] alw;
    } pkt_t;
    logic clk, rst, rd, wr, wreq, send_req, pv, rv, drop, sup, host, unm, fbd, pval;
    logic [19:0] addr;
    logic [31:0] wdata, rdata, cnt, v;
    logic [41:0] flds;
    logic [10:0] fwd;
    logic [4:0] pidx;
    logic [1:0] pprio;
    pkt_t pkt, f;
    int err_total, comparisons;
    assign f = pkt_t'(flds);
    l2_lookup_stage_model far (.i_clk(clk), .i_rst(rst), .i_send(send_req), .i_pkt(pkt),
        .o_pkt_valid(pv), .o_fields(flds));
    l2_action_filter_lookup dut (.I_SYS_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wreq), .I_PKT_VALID(pv), .I_SOURCE_PORT_STATE_BIT(f.st),
        .I_SOURCE_ACTION_LOOKUP_EN(f.en), .I_SRC_HIT(f.sh), .I_SRC_ENTRY(f.se),
        .I_DEST_HIT(f.dh), .I_DEST_ENTRY(f.de), .I_BROADCAST(f.bc), .I_STATION_MOVE(f.mv),
        .I_SRC_MAC_MC(f.mc), .I_DEST_PORTS(f.ports), .I_SPECIAL_ALLOWED(f.alw),
        .O_RES_VALID(rv), .O_FWD_PORTS(fwd), .O_DROP(drop), .O_SUPPRESS_LEARN(sup),
        .O_COPY_TO_HOST(host), .O_HOST_COPY_UNMODIFIED(unm), .O_FORBID_STATION_MOVE(fbd),
        .O_PROFILE_VALID(pval), .O_PROFILE_INDEX(pidx), .O_PROFILE_PRIORITY(pprio));
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [17:0] word, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {word, 2'b00};
        wdata <= d;
        rd <= !w;
        wr <= w;
        // Read data is taken at the very edge that sees waitrequest low.
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        v = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            chk("bus answer", 32'h1, 32'h0);
            test_done();
        end
    endtask
    task automatic rchk(input string what, input logic [17:0] word, input logic [31:0] exp);
        bus(1'b0, word, 32'h0);
        chk(what, v, exp);
    endtask
    function automatic pkt_t mk(input logic [9:0] b, input logic [10:0] ports,
        input logic [3:0] alw);
        // Unused entry bits other than dest entry bits 7 and 1 are set so a wrong bit pick changes the index.
        return '{st:b[9], en:b[8], sh:b[7], se:{b[6], 9'h1FF}, dh:b[5],
            de:{1'b1, b[3], 7'h3E, b[4]}, bc:b[2], mv:b[1], mc:b[0], ports:ports, alw:alw};
    endfunction
    task automatic send(input pkt_t p);
        int n;
        n = 0;
        @(posedge clk);
        pkt <= p;
        send_req <= 1'b1;
        @(posedge clk);
        send_req <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (rv !== 1'b1 && n < 10);
        chk("res_valid", {31'h0, rv}, 32'h1);
        chk("res latency", 32'(n), 32'h2);
    endtask
    task automatic t_regs();
        rchk("dest entry", l2_action_filter_pkg::DEST_TBL_IDX, 32'h0);
        rchk("src entry", l2_action_filter_pkg::SRC_TBL_IDX + 18'h7F, 32'h0);
        rchk("egress state", l2_action_filter_pkg::EGR_STATE_IDX, 32'h0);
        bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX + 18'h7F, 32'hFFFFFFFF);
        rchk("dest width", l2_action_filter_pkg::DEST_TBL_IDX + 18'h7F, 32'h0007FFFF);
        bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX + 18'h7F, 32'h0);
        bus(1'b1, l2_action_filter_pkg::EGR_STATE_IDX, 32'hFFFFFFFF);
        rchk("egress width", l2_action_filter_pkg::EGR_STATE_IDX, 32'h000007FF);
        bus(1'b1, l2_action_filter_pkg::EGR_STATE_IDX, 32'h00000004);
        bus(1'b1, 18'h00010, 32'h12345678);
        rchk("unmapped", 18'h00010, 32'h0);
        bus(1'b1, l2_action_filter_pkg::DROP_CNT_IDX, 32'h00000055);
        rchk("drop count ro", l2_action_filter_pkg::DROP_CNT_IDX, 32'h0);
    endtask
    task automatic t_index();
        pkt_t cs[4];
        logic [6:0] ix[4];
        cs[0] = mk(10'h2F8, 11'h004, 4'h0);
        ix[0] = 7'h4F;
        cs[1] = mk(10'h060, 11'h001, 4'h0);
        ix[1] = 7'h10;
        cs[2] = mk(10'h218, 11'h001, 4'h0);
        ix[2] = 7'h21;
        cs[3] = mk(10'h094, 11'h002, 4'h0);
        ix[3] = 7'h32;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX + 18'(ix[i]), 32'h00000020);
            send(cs[i]);
            chk("host by index", {31'h0, host}, 32'h1);
            chk("fwd kept", {21'h0, fwd}, {21'h0, cs[i].ports});
            bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX + 18'(ix[i]), 32'h0);
        end
    endtask
    task automatic t_source();
        bus(1'b1, l2_action_filter_pkg::SRC_TBL_IDX + 18'h62, 32'h00000004);
        send(mk(10'h182, 11'h000, 4'h0));
        chk("src drop", {31'h0, drop}, 32'h1);
        send(mk(10'h082, 11'h000, 4'h0));
        chk("src off", {31'h0, drop}, 32'h0);
        bus(1'b1, l2_action_filter_pkg::SRC_TBL_IDX + 18'h62, 32'h00000504);
        send(mk(10'h182, 11'h000, 4'h4));
        chk("special ok", {31'h0, drop}, 32'h0);
        send(mk(10'h182, 11'h000, 4'hB));
        chk("special no", {31'h0, drop}, 32'h1);
        cnt = 32'h2;
        rchk("drop count", l2_action_filter_pkg::DROP_CNT_IDX, cnt);
        bus(1'b1, l2_action_filter_pkg::SRC_TBL_IDX + 18'h62, 32'h0);
    endtask
    task automatic t_ports();
        bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX + 18'h40, 32'h00000008);
        send(mk(10'h030, 11'h00C, 4'h0));
        chk("port drop", {21'h0, fwd}, 32'h00000008);
        chk("no full drop", {31'h0, drop}, 32'h0);
        bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX + 18'h40, 32'h0);
        bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX, 32'h00000010);
        send(mk(10'h032, 11'h008, 4'h0));
        chk("move drop", {31'h0, drop}, 32'h1);
        send(mk(10'h030, 11'h008, 4'h0));
        chk("no move", {31'h0, drop}, 32'h0);
        cnt = 32'h4;
        rchk("drop count", l2_action_filter_pkg::DROP_CNT_IDX, cnt);
    endtask
    task automatic t_flags();
        bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX, 32'h000458E1);
        send(mk(10'h030, 11'h008, 4'h0));
        chk("learn uc", {31'h0, sup}, 32'h1);
        chk("unmodified", {31'h0, unm}, 32'h1);
        chk("forbid move", {31'h0, fbd}, 32'h1);
        chk("profile", {24'h0, pval, pidx, pprio}, 32'h00000096);
        bus(1'b1, l2_action_filter_pkg::DEST_TBL_IDX + 18'h10, 32'h00000002);
        send(mk(10'h021, 11'h008, 4'h0));
        chk("learn mc", {31'h0, sup}, 32'h1);
        send(mk(10'h020, 11'h008, 4'h0));
        chk("learn mc off", {31'h0, sup}, 32'h0);
        bus(1'b1, l2_action_filter_pkg::SRC_TBL_IDX + 18'h10, 32'h00000020);
        send(mk(10'h120, 11'h008, 4'h0));
        chk("merge host", {31'h0, host}, 32'h1);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        test_done();
    end
    initial begin
        {rst, rd, wr, send_req, addr, wdata, pkt} = {4'h8, 20'h00000, 32'h00000000, 42'h0};
        err_total = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_index();
        t_source();
        t_ports();
        t_flags();
        test_done();
    end
endmodule
`default_nettype wire
